// *** common/sysint_pkg.sv ***
// package for the stop keep-alive, short-address page, protection and port A select bank
// assumes a 16-bit register port addressed by word index, one clock, async active-low reset
//
// Contract
// - keep-alive 0 stops a clock in Stop mode; 1 keeps it if enabled
// - first keep-alive: serial bit 4, queued spi bit 2, pwm bit 0, with enable 0
// - second keep-alive: interval timer bit 12, timer channels 3..0; resets zero
// - short address takes 6 low bits from instruction, 18 from page registers
// - high page holds address bits 23:22 in bits 1-0, reset 11
// - low page holds address bits 21:6 across all 16 bits
// - new page value reaches short addressing within five cycles
// - clock protect field bits 3-2 blocks clock enable, keep-alive, rate writes
// - mux protect field bits 1-0 blocks pin, source select and gpio config writes
// - code 00 off, 01 on, 10 off locked, 11 on locked; reset 00
// - unlocked field may be switched off and on freely
// - locked field ignores writes until chip reset returns it to 00
// - mux protect also guards pwm fields of clock output control
// - peripheral enable 0 gives gpio the pin; 1 lets select fields choose
// - shared function fans out to all pins; input combines those pins
// - after reset all pins come up as gpio
// - port A select: pin6 bit 12, pin5 bits 11-10, pin4 bits 9-8; reset zero
// - accesses to a clock-disabled peripheral have no effect
// - clock enable 0 withholds clock, 1 supplies it
package sysint_pkg;

  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 16;

  // ============================================================
  // register word offsets
  localparam logic [7:0]  OFS_STOP_KEEP_0  = 8'h0e;
  localparam logic [7:0]  OFS_STOP_KEEP_1  = 8'h0f;
  localparam logic [7:0]  OFS_PAGE_HIGH    = 8'h10;
  localparam logic [7:0]  OFS_PAGE_LOW     = 8'h11;
  localparam logic [7:0]  OFS_PROTECT      = 8'h12;
  localparam logic [7:0]  OFS_PORTA_SEL_0  = 8'h13;

  // ============================================================
  // field positions
  localparam int          BIT_SERIAL_KEEP  = 4;
  localparam int          BIT_QSPI_KEEP    = 2;
  localparam int          BIT_PWM_KEEP     = 0;
  localparam int          BIT_PIT_KEEP     = 12;
  localparam int          BIT_TMR_KEEP_HI  = 3;
  localparam int          BIT_CLK_PROT_LO  = 2;
  localparam int          BIT_MUX_PROT_LO  = 0;
  localparam int          BIT_PIN6_SEL     = 12;
  localparam int          BIT_PIN5_SEL_LO  = 10;
  localparam int          BIT_PIN4_SEL_LO  = 8;
  localparam int          BIT_ENA_SERIAL   = 4;
  localparam int          BIT_ENA_QSPI     = 2;
  localparam int          BIT_ENA_PWM      = 0;
  localparam int          BIT_ENA_PIT      = 12;

  // ============================================================
  // reset values
  localparam logic [1:0]  RST_PAGE_HIGH    = 2'h3;
  localparam logic [15:0] RST_PAGE_LOW     = 16'h0000;
  localparam logic [1:0]  RST_PROT_FIELD   = 2'h0;
  localparam logic [15:0] RD_UNMAPPED      = 16'h0000;

  // ============================================================
  // protection codes: bit 0 = protect on, bit 1 = locked
  localparam int          PROT_ON_BIT      = 0;
  localparam int          PROT_LOCK_BIT    = 1;

  // pin function select codes for pins 4 and 5
  typedef enum logic [1:0] {
    SEL_PWM   = 2'b00,
    SEL_FAULT = 2'b01,
    SEL_TIMER = 2'b10,
    SEL_RSVD  = 2'b11
  } pin_sel_t;

  // ============================================================
  // timing: page settle delay in system clock cycles
  localparam logic [2:0]  PAGE_SETTLE_CYC  = 3'h5;

endpackage

// *** hw/sysint_stop_protect_regs.sv ***
// stop keep-alive, short-address page, write protection and port A pin select bank
// assumes register strobes synchronous to sysClk, one-cycle strobes, never both at once;
// clock enable registers and gpio config live outside and take the protect outputs
`timescale 1ns/1ps
`default_nettype none

module sysint_stop_protect_regs
  import sysint_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [DATA_W-1:0]   regWrData,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  output logic      [DATA_W-1:0]   regRdData,
  input  wire logic [15:0]         clockEnable0,
  input  wire logic [15:0]         clockEnable1,
  input  wire logic                stopMode,
  output logic                     serialClkRun,
  output logic                     qspiClkRun,
  output logic                     pwmClkRun,
  output logic                     pitClkRun,
  output logic      [3:0]          timerClkRun,
  output logic                     clockProtectOn,
  output logic                     muxProtectOn,
  input  wire logic [5:0]          shortOffset,
  output logic      [23:0]         shortAddr,
  input  wire logic [6:4]          pinPeriphEnable,
  input  wire logic [6:4]          gpioOut,
  input  wire logic [6:4]          gpioOutEn,
  input  wire logic [6:4]          pinIn,
  output logic      [6:4]          pinOut,
  output logic      [6:4]          pinOutEn,
  input  wire logic [5:4]          pwmOut,
  input  wire logic [3:0]          timerOut,
  input  wire logic [3:0]          timerOutEn,
  output logic      [2:0]          faultIn,
  output logic      [3:0]          timerIn
);

  // ============================================================
  // state
  typedef struct packed {
    logic [2:0]  keep0;       // serial, qspi, pwm
    logic [4:0]  keep1;       // pit, timer 3..0
    logic [1:0]  pageHigh;
    logic [15:0] pageLow;
    logic [1:0]  effHigh;
    logic [15:0] effLow;
    logic [2:0]  settleCnt;
    logic [1:0]  clkProt;
    logic [1:0]  muxProt;
    logic        pin6Sel;
    logic [1:0]  pin5Sel;
    logic [1:0]  pin4Sel;
    logic [15:0] rdData;
  } state_t;

  localparam state_t STATE_RST = '{
    keep0:     3'h0,
    keep1:     5'h00,
    pageHigh:  RST_PAGE_HIGH,
    pageLow:   RST_PAGE_LOW,
    effHigh:   RST_PAGE_HIGH,
    effLow:    RST_PAGE_LOW,
    settleCnt: 3'h0,
    clkProt:   RST_PROT_FIELD,
    muxProt:   RST_PROT_FIELD,
    pin6Sel:   1'b0,
    pin5Sel:   2'h0,
    pin4Sel:   2'h0,
    rdData:    16'h0000
  };

  state_t state_ff;
  state_t nxt_state;

  logic   wrKeep0;
  logic   wrKeep1;
  logic   wrPageHigh;
  logic   wrPageLow;
  logic   wrProt;
  logic   wrPortA;

  // ============================================================
  // write decode with protection gating
  always_comb begin
    wrKeep0    = regWrEn && regAddr == OFS_STOP_KEEP_0 && !state_ff.clkProt[PROT_ON_BIT];
    wrKeep1    = regWrEn && regAddr == OFS_STOP_KEEP_1 && !state_ff.clkProt[PROT_ON_BIT];
    wrPageHigh = regWrEn && regAddr == OFS_PAGE_HIGH;
    wrPageLow  = regWrEn && regAddr == OFS_PAGE_LOW;
    wrProt     = regWrEn && regAddr == OFS_PROTECT;
    wrPortA    = regWrEn && regAddr == OFS_PORTA_SEL_0 && !state_ff.muxProt[PROT_ON_BIT];
  end

  // ============================================================
  // next state
  always_comb begin
    nxt_state = state_ff;

    if (wrKeep0) begin
      nxt_state.keep0 = {regWrData[BIT_SERIAL_KEEP], regWrData[BIT_QSPI_KEEP], regWrData[BIT_PWM_KEEP]};
    end
    if (wrKeep1) begin
      nxt_state.keep1 = {regWrData[BIT_PIT_KEEP], regWrData[BIT_TMR_KEEP_HI:0]};
    end

    if (wrPageHigh) begin
      nxt_state.pageHigh = regWrData[1:0];
    end
    if (wrPageLow) begin
      nxt_state.pageLow = regWrData;
    end
    // the page in use follows a write after a fixed settle delay
    if (wrPageHigh || wrPageLow) begin
      nxt_state.settleCnt = PAGE_SETTLE_CYC;
    end else if (state_ff.settleCnt != 3'h0) begin
      nxt_state.settleCnt = state_ff.settleCnt - 3'h1;
    end
    if (state_ff.settleCnt == 3'h1) begin
      nxt_state.effHigh = state_ff.pageHigh;
      nxt_state.effLow  = state_ff.pageLow;
    end

    // a locked field keeps its value until reset
    if (wrProt && !state_ff.clkProt[PROT_LOCK_BIT]) begin
      nxt_state.clkProt = regWrData[BIT_CLK_PROT_LO+1:BIT_CLK_PROT_LO];
    end
    if (wrProt && !state_ff.muxProt[PROT_LOCK_BIT]) begin
      nxt_state.muxProt = regWrData[BIT_MUX_PROT_LO+1:BIT_MUX_PROT_LO];
    end

    if (wrPortA) begin
      nxt_state.pin6Sel = regWrData[BIT_PIN6_SEL];
      nxt_state.pin5Sel = regWrData[BIT_PIN5_SEL_LO+1:BIT_PIN5_SEL_LO];
      nxt_state.pin4Sel = regWrData[BIT_PIN4_SEL_LO+1:BIT_PIN4_SEL_LO];
    end

    // read data, valid the cycle after the strobe; reserved bits read zero
    nxt_state.rdData = RD_UNMAPPED;
    if (regRdEn) begin
      case (regAddr)
        OFS_STOP_KEEP_0: begin
          nxt_state.rdData[BIT_SERIAL_KEEP] = state_ff.keep0[2];
          nxt_state.rdData[BIT_QSPI_KEEP]   = state_ff.keep0[1];
          nxt_state.rdData[BIT_PWM_KEEP]    = state_ff.keep0[0];
        end
        OFS_STOP_KEEP_1: begin
          nxt_state.rdData[BIT_PIT_KEEP]        = state_ff.keep1[4];
          nxt_state.rdData[BIT_TMR_KEEP_HI:0]   = state_ff.keep1[3:0];
        end
        OFS_PAGE_HIGH: begin
          nxt_state.rdData[1:0] = state_ff.pageHigh;
        end
        OFS_PAGE_LOW: begin
          nxt_state.rdData = state_ff.pageLow;
        end
        OFS_PROTECT: begin
          nxt_state.rdData[BIT_CLK_PROT_LO+1:BIT_CLK_PROT_LO] = state_ff.clkProt;
          nxt_state.rdData[BIT_MUX_PROT_LO+1:BIT_MUX_PROT_LO] = state_ff.muxProt;
        end
        OFS_PORTA_SEL_0: begin
          nxt_state.rdData[BIT_PIN6_SEL]                      = state_ff.pin6Sel;
          nxt_state.rdData[BIT_PIN5_SEL_LO+1:BIT_PIN5_SEL_LO] = state_ff.pin5Sel;
          nxt_state.rdData[BIT_PIN4_SEL_LO+1:BIT_PIN4_SEL_LO] = state_ff.pin4Sel;
        end
        default: begin
          nxt_state.rdData = RD_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ============================================================
  // clock gate enables: enable bit, and in Stop mode also keep-alive bit
  always_comb begin
    serialClkRun = clockEnable0[BIT_ENA_SERIAL] && (!stopMode || state_ff.keep0[2]);
    qspiClkRun   = clockEnable0[BIT_ENA_QSPI]   && (!stopMode || state_ff.keep0[1]);
    pwmClkRun    = clockEnable0[BIT_ENA_PWM]    && (!stopMode || state_ff.keep0[0]);
    pitClkRun    = clockEnable1[BIT_ENA_PIT]    && (!stopMode || state_ff.keep1[4]);
    timerClkRun  = clockEnable1[3:0] & ({4{!stopMode}} | state_ff.keep1[3:0]);
  end

  // protect levels for the clock enable, rate, source select, gpio and clock output blocks
  assign clockProtectOn = state_ff.clkProt[PROT_ON_BIT];
  assign muxProtectOn   = state_ff.muxProt[PROT_ON_BIT];

  // ============================================================
  // short address
  assign regRdData = state_ff.rdData;
  assign shortAddr = {state_ff.effHigh, state_ff.effLow, shortOffset};

  // ============================================================
  // port A pin mux, pins 4..6
  logic [6:4] selPwm;
  logic [6:4] selFault;
  logic [6:4] selTimer;
  logic [1:0] pinSel [6:4];
  logic [3:0] pinTimerCh [6:4];

  always_comb begin
    pinSel[6]     = state_ff.pin6Sel ? SEL_TIMER : SEL_FAULT;
    pinSel[5]     = state_ff.pin5Sel;
    pinSel[4]     = state_ff.pin4Sel;
    pinTimerCh[6] = 4'h1;
    pinTimerCh[5] = 4'h8;
    pinTimerCh[4] = 4'h4;
  end

  genvar p;
  generate
    for (p = 4; p <= 6; p++) begin : g_pin
      assign selPwm[p]   = pinPeriphEnable[p] && pinSel[p] == SEL_PWM && p != 6;
      assign selFault[p] = pinPeriphEnable[p] && pinSel[p] == SEL_FAULT;
      assign selTimer[p] = pinPeriphEnable[p] && pinSel[p] == SEL_TIMER;
      always_comb begin
        if (!pinPeriphEnable[p]) begin
          pinOut[p]   = gpioOut[p];
          pinOutEn[p] = gpioOutEn[p];
        end else if (selPwm[p]) begin
          pinOut[p]   = pwmOut[(p == 5) ? 5 : 4];
          pinOutEn[p] = 1'b1;
        end else if (selTimer[p]) begin
          pinOut[p]   = |(timerOut & pinTimerCh[p]);
          pinOutEn[p] = |(timerOutEn & pinTimerCh[p]);
        end else begin
          pinOut[p]   = 1'b0;
          pinOutEn[p] = 1'b0;
        end
      end
    end
  endgenerate

  // peripheral inputs: OR of every pin routed to the function
  always_comb begin
    faultIn[0] = selFault[6] & pinIn[6];
    faultIn[1] = selFault[4] & pinIn[4];
    faultIn[2] = selFault[5] & pinIn[5];
    timerIn    = ({4{selTimer[6] & pinIn[6]}} & pinTimerCh[6])
               | ({4{selTimer[5] & pinIn[5]}} & pinTimerCh[5])
               | ({4{selTimer[4] & pinIn[4]}} & pinTimerCh[4]);
  end

endmodule

`default_nettype wire

// *** verification/sysint_stop_protect_regs_monitor.sv ***
// checker for the stop keep-alive, page, protection and port A select bank
// assumes it is bound to the bank's top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sysint_stop_protect_regs_monitor
  import sysint_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic              regWrEn,
  input wire logic              regRdEn,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic [15:0]       clockEnable0,
  input wire logic [15:0]       clockEnable1,
  input wire logic              stopMode,
  input wire logic              serialClkRun,
  input wire logic              pitClkRun,
  input wire logic [3:0]        timerClkRun,
  input wire logic              clockProtectOn,
  input wire logic              muxProtectOn,
  input wire logic [5:0]        shortOffset,
  input wire logic [23:0]       shortAddr,
  input wire logic [6:4]        pinPeriphEnable,
  input wire logic [6:4]        gpioOut,
  input wire logic [6:4]        pinOut
);
  // ==========================================
  // lock tracking
  logic clkLock_ff, muxLock_ff, protWr, pageWr;
  assign protWr = regWrEn && (regAddr == OFS_PROTECT);
  assign pageWr = regWrEn && (regAddr == OFS_PAGE_HIGH || regAddr == OFS_PAGE_LOW);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkLock_ff <= 1'b0;
      muxLock_ff <= 1'b0;
    end else if (protWr) begin
      clkLock_ff <= clkLock_ff | regWrData[3];
      muxLock_ff <= muxLock_ff | regWrData[1];
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  read_idle_a: assert property (!$past(regRdEn) |-> regRdData == 16'h0000)
    else $error("read data outside its slot");
  clk_gate_off_a: assert property (({serialClkRun, pitClkRun, timerClkRun} &
    ~{clockEnable0[4], clockEnable1[12], clockEnable1[3:0]}) == 6'h00) else $error("clock without enable");
  run_awake_a: assert property (!stopMode |-> {serialClkRun, pitClkRun, timerClkRun} ==
    {clockEnable0[4], clockEnable1[12], clockEnable1[3:0]}) else $error("clock wrong outside stop");
  offset_pass_a: assert property (shortAddr[5:0] == shortOffset) else $error("short offset wrong");
  page_reset_a: assert property ($rose(rst_n) |-> shortAddr[23:6] == {2'h3, 16'h0000})
    else $error("page not at reset value");
  page_low_a: assert property (regWrEn && regAddr == OFS_PAGE_LOW ##1 !pageWr [*5] |->
    ##1 shortAddr[21:6] == $past(regWrData, 6)) else $error("low page not applied");
  page_high_a: assert property (regWrEn && regAddr == OFS_PAGE_HIGH ##1 !pageWr [*5] |->
    ##1 shortAddr[23:22] == $past(regWrData[1:0], 6)) else $error("high page not applied");
  clk_prot_wr_a: assert property (protWr && !clkLock_ff |=> clockProtectOn == $past(regWrData[2]))
    else $error("clock protect not written");
  clk_lock_a: assert property (clkLock_ff |=> $stable(clockProtectOn)) else $error("locked clock protect moved");
  mux_prot_wr_a: assert property (protWr && !muxLock_ff |=> muxProtectOn == $past(regWrData[0]))
    else $error("mux protect not written");
  mux_lock_a: assert property (muxLock_ff |=> $stable(muxProtectOn)) else $error("locked mux protect moved");
  gpio_pin_a: assert property ((pinOut & ~pinPeriphEnable) == (gpioOut & ~pinPeriphEnable))
    else $error("gpio pin not under gpio");
endmodule
`default_nettype wire

// *** verification/tb_sysint_stop_protect_regs.sv ***
// testbench for the stop keep-alive, page, protection and port A select bank
// assumes the bank package and the monitor file are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_sysint_stop_protect_regs;
  import sysint_pkg::*;
  logic        sys_clk, rst_n, regWrEn, regRdEn, stopMode, clockProtectOn, muxProtectOn;
  logic        serialClkRun, qspiClkRun, pwmClkRun, pitClkRun;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData, clockEnable0, clockEnable1;
  logic [3:0]  timerClkRun, timerOut, timerOutEn, timerIn;
  logic [5:0]  shortOffset;
  logic [23:0] shortAddr;
  logic [6:4]  pinPeriphEnable, gpioOut, gpioOutEn, pinIn, pinOut, pinOutEn;
  logic [5:4]  pwmOut;
  logic [2:0]  faultIn;
  int          error_cnt, n_compared, cycles;
  sysint_stop_protect_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .clockEnable0(clockEnable0),
    .clockEnable1(clockEnable1), .stopMode(stopMode), .serialClkRun(serialClkRun), .qspiClkRun(qspiClkRun),
    .pwmClkRun(pwmClkRun), .pitClkRun(pitClkRun), .timerClkRun(timerClkRun), .clockProtectOn(clockProtectOn),
    .muxProtectOn(muxProtectOn), .shortOffset(shortOffset), .shortAddr(shortAddr),
    .pinPeriphEnable(pinPeriphEnable), .gpioOut(gpioOut), .gpioOutEn(gpioOutEn), .pinIn(pinIn),
    .pinOut(pinOut), .pinOutEn(pinOutEn), .pwmOut(pwmOut), .timerOut(timerOut), .timerOutEn(timerOutEn),
    .faultIn(faultIn), .timerIn(timerIn));
  // ==========================================
  // shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    chk(24'(regRdData), 24'(exp), what);
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic test_reset_values();
    rd(OFS_STOP_KEEP_0, 16'h0000, "keep0");
    rd(OFS_STOP_KEEP_1, 16'h0000, "keep1");
    rd(OFS_PAGE_HIGH, 16'h0003, "page high");
    rd(OFS_PAGE_LOW, 16'h0000, "page low");
    rd(OFS_PROTECT, 16'h0000, "protect");
    rd(OFS_PORTA_SEL_0, 16'h0000, "port a");
    rd(8'h20, 16'h0000, "unmapped");
  endtask
  task automatic test_keep();
    wr(OFS_STOP_KEEP_0, 16'h0015);
    rd(OFS_STOP_KEEP_0, 16'h0015, "keep0 bits");
    wr(OFS_STOP_KEEP_1, 16'h100f);
    rd(OFS_STOP_KEEP_1, 16'h100f, "keep1 bits");
    clockEnable0 <= 16'hffff;
    clockEnable1 <= 16'hffff;
    stopMode <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(24'({serialClkRun, qspiClkRun, pwmClkRun, pitClkRun, timerClkRun}), 24'hff, "stop all kept");
    wr(OFS_STOP_KEEP_1, 16'h0005);
    #1;
    chk(24'({serialClkRun, qspiClkRun, pwmClkRun, pitClkRun, timerClkRun}), 24'he5, "stop partial");
    clockEnable0 <= 16'h0004;
    @(posedge sys_clk);
    #1;
    chk(24'({serialClkRun, qspiClkRun, pwmClkRun, pitClkRun, timerClkRun}), 24'h45, "stop enable");
    stopMode <= 1'b0;
    clockEnable1 <= 16'h0000;
    @(posedge sys_clk);
    #1;
    chk(24'({serialClkRun, qspiClkRun, pwmClkRun, pitClkRun, timerClkRun}), 24'h40, "run enable");
  endtask
  task automatic test_page();
    shortOffset <= 6'h2a;
    wr(OFS_PAGE_LOW, 16'ha5c3);
    #1;
    chk(shortAddr, {2'h3, 16'h0000, 6'h2a}, "page too early");
    wr(OFS_PAGE_HIGH, 16'h0001);
    rd(OFS_PAGE_HIGH, 16'h0001, "page high rd");
    rd(OFS_PAGE_LOW, 16'ha5c3, "page low rd");
    repeat (4) @(posedge sys_clk);
    #1;
    chk(shortAddr, {2'h1, 16'ha5c3, 6'h2a}, "short addr");
  endtask
  task automatic test_protect();
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr(OFS_PROTECT, 16'(c * 5));
      rd(OFS_PROTECT, 16'(c * 5), "protect code");
      chk(24'({clockProtectOn, muxProtectOn}), c[0] ? 24'h3 : 24'h0, "protect out");
      wr(OFS_STOP_KEEP_1, 16'h1001);
      rd(OFS_STOP_KEEP_1, c[0] ? 16'h0000 : 16'h1001, "keep guarded");
      wr(OFS_PORTA_SEL_0, 16'h1500);
      rd(OFS_PORTA_SEL_0, c[0] ? 16'h0000 : 16'h1500, "select guarded");
      wr(OFS_PROTECT, c[0] ? 16'h0000 : 16'h0005);
      rd(OFS_PROTECT, c[1] ? 16'(c * 5) : (c[0] ? 16'h0000 : 16'h0005), "protect change");
    end
  endtask
  task automatic test_pins();
    gpioOut <= 3'b101;
    gpioOutEn <= 3'b011;
    pinIn <= 3'b110;
    pwmOut <= 2'b01;
    timerOut <= 4'b1010;
    timerOutEn <= 4'b1111;
    @(posedge sys_clk);
    #1;
    chk(24'({pinOut, pinOutEn}), 24'h2b, "pins gpio");
    pinPeriphEnable <= 3'b111;
    @(posedge sys_clk);
    #1;
    chk(24'({pinOut[5:4], faultIn[0]}), 24'h3, "default funcs");
    wr(OFS_PORTA_SEL_0, 16'h1a00);
    #1;
    chk(24'({pinOut, pinOutEn, timerIn[3:2], timerIn[0]}), 24'hbd, "timer funcs");
    // old functions released and left idle before the new ones are enabled
    pinPeriphEnable <= 3'b000;
    repeat (2) @(posedge sys_clk);
    wr(OFS_PORTA_SEL_0, 16'h0500);
    pinPeriphEnable <= 3'b111;
    @(posedge sys_clk);
    #1;
    chk(24'(faultIn), 24'h5, "fault funcs");
  endtask
  // ==========================================
  // clock, timeout and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("MISMATCH t=%0t timeout", $time);
      end_of_test();
    end
  end
  initial begin
    {rst_n, regWrEn, regRdEn, stopMode, regAddr, regWrData} = '0;
    {clockEnable0, clockEnable1, shortOffset, pinPeriphEnable, gpioOut, gpioOutEn} = '0;
    {pinIn, pwmOut, timerOut, timerOutEn} = '0;
    do_reset();
    test_reset_values();
    test_keep();
    test_page();
    test_protect();
    do_reset();
    test_reset_values();
    test_pins();
    end_of_test();
  end
endmodule
bind sysint_stop_protect_regs sysint_stop_protect_regs_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .clockEnable0(clockEnable0), .clockEnable1(clockEnable1), .stopMode(stopMode), .serialClkRun(serialClkRun),
  .pitClkRun(pitClkRun), .timerClkRun(timerClkRun), .clockProtectOn(clockProtectOn),
  .muxProtectOn(muxProtectOn), .shortOffset(shortOffset), .shortAddr(shortAddr),
  .pinPeriphEnable(pinPeriphEnable), .gpioOut(gpioOut), .pinOut(pinOut));
`default_nettype wire
